/* File: hcc_counter_ctrl.sv */
// Count enable, reset, preset and value change control for channel 0.
//
// Overview of operation
// - Count only while enable flag is active.
// - Enable from software bit, control 0, control 1.
// - Control input enable ignores software enable bit.
// - Configured reset condition clears count to zero.
// - Reset from software, Z input, match status.
// - Z and match reset need reset-enable bit.
// - Configured preset condition loads stored preset.
// - Preset from software bit or Z input.
// - Preset register updates only on change request.
// - Enable-reset mode clears count on enabling.
// - Enable-preset mode loads preset on enabling.
// - Count is zero after power-up.
// - Staged current value loaded on change request.
// - Functions act only after operation ready.
// - Count is signed 32-bit full range.
`include "hcc_defs.svh"

module hcc_counter_ctrl
  import hcc_pkg::*;
#(
  parameter int WIDTH = `HCC_COUNT_WIDTH
)
(
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire hcc_pkg::hcc_cfg_s   cfg,
  input  wire hcc_pkg::hcc_req_s   req,
  input  wire logic                paramsValid,
  input  wire logic                ctrl0In,
  input  wire logic                ctrl1In,
  input  wire logic                zPhaseIn,
  input  wire logic                matchStatus,
  input  wire logic                countStep,
  input  wire logic                countDown,
  input  wire logic signed [WIDTH-1:0] chan0_staged_current_value,
  input  wire logic                chan0_current_load_req,
  input  wire logic signed [WIDTH-1:0] chan0_staged_preset_value,
  input  wire logic                chan0_preset_update_req,
  output logic signed [WIDTH-1:0]  chan0_count_readback,
  output logic                     opReadyStatus,
  output logic                     countEnabled
);
  import hcc_pkg::*;

  logic signed [WIDTH-1:0] count_q;
  logic signed [WIDTH-1:0] count_d;
  logic signed [WIDTH-1:0] preset_q;
  logic                    ready_q;
  logic                    ctrl0Act;
  logic                    ctrl1Act;
  logic                    enableNow;
  logic                    zHit;
  logic                    matchRise;
  logic                    matchFall;
  logic                    enRise;
  logic                    doReset;
  logic                    doPreset;
  logic                    doLoad;

  // Flag is active when the pin matches its configured logic sense.
  function automatic logic active_level(input logic pin, input logic neg);
    active_level = pin ^ neg;
  endfunction : active_level

  assign ctrl0Act = active_level(ctrl0In, cfg.ctrl0NegLogic);
  assign ctrl1Act = active_level(ctrl1In, cfg.ctrl1NegLogic);

  always_comb
  begin
    unique case (cfg.enSrc)
      HCC_EN_CTRL0: enableNow = ctrl0Act;
      HCC_EN_CTRL1: enableNow = ctrl1Act;
      default:      enableNow = req.countEnableReq;
    endcase
  end

  hcc_trig_detect u_zDet (
    .clk_sys (clk_sys),
    .rst     (rst),
    .sigIn   (zPhaseIn),
    .trigSel (cfg.zTrig),
    .hit     (zHit)
  );

  hcc_trig_detect u_matchRise (
    .clk_sys (clk_sys),
    .rst     (rst),
    .sigIn   (matchStatus),
    .trigSel (HCC_TRIG_RISE),
    .hit     (matchRise)
  );

  hcc_trig_detect u_matchFall (
    .clk_sys (clk_sys),
    .rst     (rst),
    .sigIn   (matchStatus),
    .trigSel (HCC_TRIG_FALL),
    .hit     (matchFall)
  );

  // The active-sense conversion makes a negative-logic falling pin edge
  // look like a rising edge here, so one detector serves both senses.
  hcc_trig_detect u_enDet (
    .clk_sys (clk_sys),
    .rst     (rst),
    .sigIn   (ctrl0Act),
    .trigSel (HCC_TRIG_RISE),
    .hit     (enRise)
  );

  // Ready follows the held request; parameters out of range keep it low.
  // Dropping the request takes ready away again on the next edge, so
  // every counter function stops as soon as software lets go.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ready_q <= 1'b0;
    end
    else
    begin
      ready_q <= req.opReadyReq & paramsValid;
    end
  end

  // Software reset acts as a level. The Z and match sources also need
  // the reset-enable bit, so a stray edge cannot wipe the count.
  always_comb
  begin
    doReset = req.resetReq;
    if (req.resetEnableReq)
    begin
      if (cfg.zFunc == HCC_Z_RESET && zHit)
      begin
        doReset = 1'b1;
      end
      if (cfg.matchFunc == HCC_M_RISE && matchRise)
      begin
        doReset = 1'b1;
      end
      if (cfg.matchFunc == HCC_M_FALL && matchFall)
      begin
        doReset = 1'b1;
      end
    end
    if (cfg.ctrl0Mode == HCC_C0_EN_RESET && enRise)
    begin
      doReset = 1'b1;
    end
  end

  // Preset sources carry no enable bit of their own.
  always_comb
  begin
    doPreset = req.presetReq;
    if (cfg.zFunc == HCC_Z_PRESET && zHit)
    begin
      doPreset = 1'b1;
    end
    if (cfg.ctrl0Mode == HCC_C0_EN_PRESET && enRise)
    begin
      doPreset = 1'b1;
    end
  end

  // The change request is a level, so a held request keeps reloading.
  assign doLoad = chan0_current_load_req;

  // The stored preset only moves on an explicit change request.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      preset_q <= `HCC_PRESET_RESET;
    end
    else if (ready_q && chan0_preset_update_req)
    begin
      preset_q <= chan0_staged_preset_value;
    end
  end

  // Priority: value change wins over preset, preset over reset, since
  // the if-else chain takes the first request that is set. Any of them
  // suspends counting for that cycle.
  always_comb
  begin
    count_d = count_q;
    if (doLoad)
    begin
      count_d = chan0_staged_current_value;
    end
    else if (doPreset)
    begin
      count_d = preset_q;
    end
    else if (doReset)
    begin
      count_d = `HCC_CLEAR_VALUE;
    end
    else if (enableNow && countStep)
    begin
      // Two's complement wrap keeps the full signed range.
      if (countDown)
      begin
        count_d = count_q - 1'b1;
      end
      else
      begin
        count_d = count_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      count_q <= `HCC_COUNT_RESET;
    end
    else if (ready_q)
    begin
      count_q <= count_d;
    end
  end

  // Readback shows the stored count. Before ready nothing is stored, so
  // a pending load must not leak out as a value that never took effect.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      chan0_count_readback <= `HCC_COUNT_RESET;
    end
    else if (ready_q)
    begin
      chan0_count_readback <= count_d;
    end
    else
    begin
      chan0_count_readback <= count_q;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      opReadyStatus <= 1'b0;
    end
    else
    begin
      opReadyStatus <= ready_q;
    end
  end

  // The enable status only claims counting once the channel is ready.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      countEnabled <= 1'b0;
    end
    else
    begin
      countEnabled <= ready_q & enableNow;
    end
  end
endmodule : hcc_counter_ctrl

/* File: hcc_defs.svh */
// Constants for the counter enable, reset and preset control block.
`ifndef HCC_DEFS_SVH
`define HCC_DEFS_SVH
`define HCC_COUNT_WIDTH 32
`define HCC_COUNT_RESET 32'h0000_0000
`define HCC_CLEAR_VALUE 32'h0000_0000
`define HCC_PRESET_RESET 32'h0000_0000
`endif

/* File: hcc_pkg.sv */
// Types shared by the counter enable, reset and preset control block.
package hcc_pkg;
  typedef enum logic [1:0] {
    HCC_EN_SW,
    HCC_EN_CTRL0,
    HCC_EN_CTRL1
  } hcc_en_src_e;
  typedef enum logic [1:0] {
    HCC_TRIG_RISE,
    HCC_TRIG_FALL,
    HCC_TRIG_HIGH,
    HCC_TRIG_LOW
  } hcc_trig_e;
  typedef enum logic [1:0] {
    HCC_C0_PLAIN,
    HCC_C0_EN_RESET,
    HCC_C0_EN_PRESET
  } hcc_c0_mode_e;
  typedef enum logic [1:0] {
    HCC_Z_NONE,
    HCC_Z_RESET,
    HCC_Z_PRESET
  } hcc_z_func_e;
  typedef enum logic [1:0] {
    HCC_M_NONE,
    HCC_M_RISE,
    HCC_M_FALL
  } hcc_match_func_e;
  // Static channel configuration.
  typedef struct packed {
    hcc_en_src_e     enSrc;
    logic            ctrl0NegLogic;
    logic            ctrl1NegLogic;
    hcc_c0_mode_e    ctrl0Mode;
    hcc_z_func_e     zFunc;
    hcc_trig_e       zTrig;
    hcc_match_func_e matchFunc;
  } hcc_cfg_s;
  // Software request bits.
  typedef struct packed {
    logic opReadyReq;
    logic countEnableReq;
    logic resetReq;
    logic resetEnableReq;
    logic presetReq;
  } hcc_req_s;
endpackage : hcc_pkg

/* File: hcc_trig_detect.sv */
// Edge or level condition detector for one control flag.
module hcc_trig_detect
  import hcc_pkg::*;
(
  input  wire logic      clk_sys,
  input  wire logic      rst,
  input  wire logic      sigIn,
  input  wire hcc_trig_e trigSel,
  output logic           hit
);
  logic prev_q;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      prev_q <= 1'b0;
    else
      prev_q <= sigIn;
  end

  always_comb
  begin
    unique case (trigSel)
      HCC_TRIG_RISE: hit = sigIn & ~prev_q;
      HCC_TRIG_FALL: hit = ~sigIn & prev_q;
      HCC_TRIG_HIGH: hit = sigIn;
      HCC_TRIG_LOW:  hit = ~sigIn;
    endcase
  end
endmodule : hcc_trig_detect

/* File: hcc_counter_ctrl_properties.sv */
// Port level assertions for the counter control block.
module hcc_ctrl_chk
  import hcc_pkg::*;
#(
  parameter int WIDTH = 32
)
(
  input wire logic                    clk_sys,
  input wire logic                    rst,
  input wire hcc_pkg::hcc_cfg_s       cfg,
  input wire hcc_pkg::hcc_req_s       req,
  input wire logic                    paramsValid,
  input wire logic                    ctrl1In,
  input wire logic                    countStep,
  input wire logic                    countDown,
  input wire logic signed [WIDTH-1:0] chan0_staged_current_value,
  input wire logic                    chan0_current_load_req,
  input wire logic signed [WIDTH-1:0] chan0_count_readback,
  input wire logic                    opReadyStatus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [WIDTH-1:0] rb;
  logic             sw;
  logic             q;
  assign rb = chan0_count_readback;
  assign sw = cfg.enSrc == HCC_EN_SW && req.countEnableReq;
  // Quiet means no source other than counting may move the value.
  assign q = opReadyStatus && !chan0_current_load_req && !req.presetReq
    && !req.resetReq && cfg.zFunc == HCC_Z_NONE
    && cfg.matchFunc == HCC_M_NONE && cfg.ctrl0Mode == HCC_C0_PLAIN;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_boot; disable iff (1'h0) rst |=> rb == 0; endproperty
  a_boot: assert property (p_boot) else $error("count not zero");
  property p_rdy;
    $rose(opReadyStatus) |-> $past(req.opReadyReq && paramsValid, 2);
  endproperty
  a_rdy: assert property (p_rdy) else $error("early ready");
  property p_drop;
    !(req.opReadyReq && paramsValid) |-> ##2 !opReadyStatus;
  endproperty
  a_drop: assert property (p_drop) else $error("ready stuck");
  property p_load; opReadyStatus && chan0_current_load_req
    |=> rb == $past(chan0_staged_current_value); endproperty
  a_load: assert property (p_load) else $error("load lost");
  property p_clr; opReadyStatus && req.resetReq && !req.presetReq
    && !chan0_current_load_req |=> rb == 0; endproperty
  a_clr: assert property (p_clr) else $error("reset lost");
  property p_up; sw ##1 (q && sw && countStep) |=> rb == $past(rb)
    + ($past(countDown) ? 32'hffff_ffff : 32'h1); endproperty
  a_up: assert property (p_up) else $error("bad step");
  property p_hold; q && cfg.enSrc == HCC_EN_SW && !req.countEnableReq
    |=> $stable(rb); endproperty
  a_hold: assert property (p_hold) else $error("moved");
  property p_ign; (q && cfg.enSrc == HCC_EN_CTRL1
    && ctrl1In == cfg.ctrl1NegLogic) [*2] |=> $stable(rb); endproperty
  a_ign: assert property (p_ign) else $error("moved off");
endmodule : hcc_ctrl_chk
bind hcc_counter_ctrl hcc_ctrl_chk #(.WIDTH(WIDTH)) u_hcc_ctrl_chk (
  .clk_sys, .rst, .cfg, .req, .paramsValid, .ctrl1In, .countStep,
  .countDown, .chan0_staged_current_value, .chan0_current_load_req,
  .chan0_count_readback, .opReadyStatus);

/* File: hcc_sw_model.sv */
// Software side model of one staged value channel and its request.
module hcc_sw_model
(
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               writeCmd,
  input  wire logic signed [31:0] writeVal,
  output logic signed [31:0]      stagedVal,
  output logic                    changeReq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pend_q;
  // Staging one edge early keeps the value still while the request is up.
  always_ff @(posedge clk_sys)
  begin
    if (writeCmd)
      stagedVal <= writeVal;
    pend_q <= writeCmd && !rst;
    changeReq <= pend_q;
  end
endmodule : hcc_sw_model

/* File: hcc_counter_ctrl_bench.sv */
// Self-checking bench for the counter enable, reset and preset control.
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR %s exp %h got %h", n, e, a); end end
module hcc_counter_ctrl_bench
  import hcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic en, st, dn; logic [31:0] ex;} hcc_row_s;
  hcc_row_s rows [4] = '{'{1'h1, 1'h1, 1'h0, 32'h8000_0000},
    '{1'h1, 1'h1, 1'h1, 32'h7fff_ffff}, '{1'h0, 1'h1, 1'h0, 32'h7fff_ffff},
    '{1'h1, 1'h1, 1'h1, 32'h7fff_fffe}};
  logic clk_sys = 0, rst = 1, paramsValid = 0, ctrl0In = 0, ctrl1In = 0;
  logic zPhaseIn = 0, countStep = 0, countDown = 0, curCmd = 0, preCmd = 0;
  logic curReq, preReq, opReadyStatus, cen;
  logic mst = 0;
  logic signed [31:0] wVal = '0, curStg, preStg, rb;
  hcc_cfg_s cfg = '0;
  hcc_req_s req = '0;
  int mismatches = 0, checked = 0;
  hcc_sw_model u_hcc_sw_model (.clk_sys, .rst, .writeCmd(curCmd),
    .writeVal(wVal), .stagedVal(curStg), .changeReq(curReq));
  hcc_sw_model u_hcc_sw_model_pre (.clk_sys, .rst, .writeCmd(preCmd),
    .writeVal(wVal), .stagedVal(preStg), .changeReq(preReq));
  hcc_counter_ctrl u_hcc_counter_ctrl (.clk_sys, .rst, .cfg, .req,
    .paramsValid, .ctrl0In, .ctrl1In, .zPhaseIn, .matchStatus(mst),
    .countStep, .countDown, .chan0_staged_current_value(curStg),
    .chan0_current_load_req(curReq), .chan0_staged_preset_value(preStg),
    .chan0_preset_update_req(preReq), .chan0_count_readback(rb),
    .opReadyStatus, .countEnabled(cen));
  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic put(input logic pre, input logic [31:0] v);
    wVal = v;
    {preCmd, curCmd} = {pre, !pre};
    step(1);
    {preCmd, curCmd} = 2'h0;
    step(3);
  endtask : put
  task automatic complete_run();
    if (mismatches == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  initial
  begin
    #40000;
    mismatches++;
    complete_run();
  end
  initial
  begin
    step(6);
    rst = 0;
    put(0, 32'h5);
    {req.opReadyReq, paramsValid} = 2'h3;
    step(3);
    `CHK("boot", 32'h0, rb)
    `CHK("ready", 1'h1, opReadyStatus)
    put(0, 32'h7fff_ffff);
    foreach (rows[i])
    begin
      {req.countEnableReq, countStep, countDown} = rows[i][34:32];
      step(1);
      `CHK("count", rows[i].ex, rb)
    end
    countStep = 0;
    put(1, 32'h1234);
    `CHK("hold", 32'h7fff_fffe, rb)
    req.presetReq = 1;
    step(1);
    req.presetReq = 0;
    `CHK("preset", 32'h1234, rb)
    req.resetReq = 1;
    step(1);
    req.resetReq = 0;
    `CHK("reset", 32'h0, rb)
    for (int t = 0; t < 5; t++)
    begin
      cfg.zFunc = HCC_Z_NONE;
      put(0, 32'h77);
      req.resetEnableReq = (t != 0);
      cfg.zTrig = hcc_trig_e'(t == 0 ? 0 : t - 1);
      cfg.zFunc = HCC_Z_RESET;
      zPhaseIn = 1;
      step(3);
      zPhaseIn = 0;
      step(3);
      `CHK("zreset", (t == 0) ? 32'h77 : 32'h0, rb)
    end
    cfg.zFunc = HCC_Z_NONE;
    // The software enable stays on here on purpose to prove it is ignored.
    cfg.enSrc = HCC_EN_CTRL1;
    {cfg.ctrl1NegLogic, ctrl1In, countStep} = 3'h7;
    step(4);
    `CHK("ignored", 32'h0, rb)
    req.countEnableReq = 0;
    ctrl1In = 0;
    step(4);
    countStep = 0;
    `CHK("ctrl1", 1'h1, rb != 0)
    cfg.enSrc = HCC_EN_CTRL0;
    for (int m = 1; m < 3; m++)
    begin
      {cfg.ctrl0NegLogic, ctrl0In} = {2{m == 2}};
      cfg.ctrl0Mode = hcc_c0_mode_e'(m);
      put(0, 32'h55);
      ctrl0In = !ctrl0In;
      step(3);
      `CHK("ctrl0", (m == 1) ? 32'h0 : 32'h1234, rb)
    end
    `CHK("cen", 1'h1, cen)
    cfg.ctrl0Mode = HCC_C0_PLAIN;
    cfg.matchFunc = HCC_M_RISE;
    mst = 1;
    step(2);
    `CHK("mrise", 32'h0, rb)
    cfg.matchFunc = HCC_M_FALL;
    put(0, 32'h99);
    mst = 0;
    step(2);
    `CHK("mfall", 32'h0, rb)
    cfg.matchFunc = HCC_M_NONE;
    cfg.zTrig = HCC_TRIG_RISE;
    cfg.zFunc = HCC_Z_PRESET;
    put(0, 32'h99);
    zPhaseIn = 1;
    step(2);
    `CHK("zpreset", 32'h1234, rb)
    zPhaseIn = 0;
    cfg.zFunc = HCC_Z_NONE;
    rst = 1;
    step(2);
    `CHK("rstcount", 32'h0, rb)
    `CHK("rstready", 1'h0, opReadyStatus)
    rst = 0;
    step(3);
    `CHK("reready", 1'h1, opReadyStatus)
    complete_run();
  end
endmodule : hcc_counter_ctrl_bench
